// *** logic/dif_mapper.sv ***
// Drive input function mapper: terminal decode, config registers, run command decode.
//
// Function
// [R01] Forward input active drives phases U-V-W; released means decelerate.
// [R02] Reverse input active drives phases W-V-U; released means decelerate.
// [R03] Forward and reverse both active removes drive so the motor coasts.
// [R04] No power-up start interlock; an active run input starts at once.
// [R05] Six function-select registers, one per programmable terminal.
// [R06] A second bank of six selects replaces the first when set two is active.
// [R07] A function code may sit on only one terminal; duplicates are refused.
// [R08] After reset every terminal is normally open.
// [R09] Outside party activates by applying 24 V and deactivates by removing it.
// [R10] Codes 00/01 forward/reverse; 02 to 05 fixed-frequency bits LSB first.
// [R11] Codes 06 to 09: jog, DC brake, set-two select, second ramp.
// [R12] Codes 11,12,13,15,16,18: coast, fault, start guard, lock, analog, reset.
// [R13] Code 19 thermistor is accepted on terminal five only.
// [R14] Codes 20,21,22: three-wire start, stop and direction.
// [R15] Codes 23,24,27,28,29: loop enable, integral clear, pot up/down/clear.
// [R16] Codes 31,50,51,52,53: keypad, offset add, terminal, fast, special set.
// [R17] Per-terminal polarity: 00 high activates, 01 low activates.
// [R18] Fault reset and thermistor terminals are always normally open.
// [R19] Polarity acts live; flipping an open run input starts the motor.
// [R20] Storage failure raises a distinct flag that marks the config suspect.
// [R21] Code 255 leaves a terminal unassigned and driving nothing.
// [R22] Select and polarity writes are refused while the drive runs.
`default_nettype none
`include "dif_defines.svh"
module dif_mapper #(
  parameter int NUM_IN = 6
) (
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic [4:0]     reg_addr,
  input  wire logic [7:0]     reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output var  logic [7:0]     reg_rdata_q,
  input  wire logic [5:0]     term_level,
  input  wire logic           drive_running,
  input  wire logic           nvm_fault,
  output var  dif_pkg::dif_func_t  func_q,
  output var  dif_pkg::dif_drive_t drive_q,
  output var  logic           set2_active_q,
  output var  logic           cfg_reject_q,
  output var  logic           nvm_suspect_q
);

  // Storage is built for six terminals; NUM_IN bounds the decoded register index.
  dif_pkg::dif_bank_t bank1_q;
  dif_pkg::dif_bank_t bank2_q;
  logic [5:0]         pol_q;

  function automatic logic dif_legal(input logic [7:0] c);
    logic ok;
    ok = 1'b0;
    case (c)
      `DIF_FN_FWD, `DIF_FN_REV, `DIF_FN_FF0, `DIF_FN_FF1, `DIF_FN_FF2,
      `DIF_FN_FF3, `DIF_FN_JOG, `DIF_FN_DCB, `DIF_FN_SET2, `DIF_FN_RAMP2,
      `DIF_FN_COAST, `DIF_FN_EXTF, `DIF_FN_USG, `DIF_FN_LOCK, `DIF_FN_ANA,
      `DIF_FN_FRST, `DIF_FN_THERM, `DIF_FN_3START, `DIF_FN_3STOP,
      `DIF_FN_3DIR, `DIF_FN_PLOOP, `DIF_FN_ICLR, `DIF_FN_POTUP,
      `DIF_FN_POTDN, `DIF_FN_POTCLR, `DIF_FN_KEYPAD, `DIF_FN_FADD,
      `DIF_FN_TERMPRI, `DIF_FN_FAST, `DIF_FN_SPSET, `DIF_FN_NONE: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // True when code c, unless it is code 255, already sits on a terminal of bank b other than i.
  function automatic logic dif_dup(input dif_pkg::dif_bank_t b,
                                   input logic [2:0] i,
                                   input logic [7:0] c);
    logic d;
    d = 1'b0;
    for (int j = 0; j < 6; j++) begin
      if (3'(j) != i && b[j] == c && c != `DIF_FN_NONE) begin
        d = 1'b1;
      end
    end
    return d;
  endfunction

  function automatic logic dif_any_dup(input dif_pkg::dif_bank_t b);
    logic d;
    d = 1'b0;
    for (int j = 0; j < 6; j++) begin
      if (dif_dup(b, 3'(j), b[j])) begin
        d = 1'b1;
      end
    end
    return d;
  endfunction

  // Per-terminal active level for a bank under the current polarity.
  function automatic logic [5:0] dif_act(input dif_pkg::dif_bank_t b,
                                         input logic [5:0] pol,
                                         input logic [5:0] lvl);
    logic [5:0] a;
    a = 6'h00;
    for (int j = 0; j < 6; j++) begin
      if (b[j] == `DIF_FN_NONE) begin
        a[j] = 1'b0; // [R21]
      end else if (b[j] == `DIF_FN_FRST || b[j] == `DIF_FN_THERM) begin
        a[j] = lvl[j]; // [R18]
      end else begin
        a[j] = lvl[j] ^ pol[j]; // [R17] [R19]
      end
    end
    return a;
  endfunction

  function automatic logic dif_hit(input dif_pkg::dif_bank_t b,
                                   input logic [5:0] a,
                                   input logic [7:0] c);
    logic h;
    h = 1'b0;
    for (int j = 0; j < 6; j++) begin
      if (a[j] && b[j] == c) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction

  // Register decode.
  wire logic [2:0] idx      = reg_addr[2:0];
  wire logic       idx_ok   = idx < 3'(NUM_IN);
  wire logic       sel_b1   = reg_addr[4:3] == `DIF_OFS_BANK1 && idx_ok;
  wire logic       sel_b2   = reg_addr[4:3] == `DIF_OFS_BANK2 && idx_ok;
  wire logic       sel_pol  = reg_addr[4:3] == `DIF_OFS_POL && idx_ok;
  wire logic       sel_st   = reg_addr == `DIF_OFS_STATUS;
  wire logic       cfg_wr   = reg_wr && (sel_b1 || sel_b2 || sel_pol);
  wire dif_pkg::dif_bank_t wr_bank = sel_b2 ? bank2_q : bank1_q;

  // A code write must be legal, unique in its bank and placed where allowed.
  wire logic code_ok = dif_legal(reg_wdata) // [R10] [R11] [R12]
                    && !(reg_wdata == `DIF_FN_THERM && idx != `DIF_THERM_INPUT) // [R13]
                    && !dif_dup(wr_bank, idx, reg_wdata); // [R07]
  wire logic pol_ok  = reg_wdata[7:1] == 7'h00;
  wire logic wr_ok   = cfg_wr && !drive_running // [R22]
                    && (sel_pol ? pol_ok : code_ok);
  wire logic rej_set = cfg_wr && !wr_ok;
  wire logic st_wr   = reg_wr && sel_st;

  // Sticky flags: a new event in the clearing cycle wins over the clear.
  wire logic rej_d = rej_set
                  || (cfg_reject_q && !(st_wr && reg_wdata[`DIF_ST_REJECT]));
  wire logic sus_d = nvm_fault // [R20]
                  || (nvm_suspect_q && !(st_wr && reg_wdata[`DIF_ST_SUSPECT]));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bank1_q <= `DIF_RST_BANK; // [R05]
      bank2_q <= `DIF_RST_BANK; // [R06]
      pol_q   <= `DIF_RST_POL; // [R08]
    end else if (wr_ok) begin
      if (sel_b1) begin
        bank1_q[idx] <= reg_wdata;
      end
      if (sel_b2) begin
        bank2_q[idx] <= reg_wdata;
      end
      if (sel_pol) begin
        pol_q[idx] <= reg_wdata[0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_reject_q  <= 1'b0;
      nvm_suspect_q <= 1'b0;
    end else begin
      cfg_reject_q  <= rej_d;
      nvm_suspect_q <= sus_d;
    end
  end

  // Read data appears in the cycle after the strobe; unmapped reads give zero.
  wire logic [7:0] status_w = {4'h0, drive_running, set2_active_q,
                               nvm_suspect_q, cfg_reject_q};
  wire logic [7:0] rd_word  = sel_b1  ? bank1_q[idx] :
                              sel_b2  ? bank2_q[idx] :
                              sel_pol ? {7'h00, pol_q[idx]} :
                              sel_st  ? status_w : 8'h00;
  wire logic [7:0] rdata_d  = reg_rd ? rd_word : 8'h00;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // Set two is chosen from the first bank so the selection cannot feed itself.
  wire logic [5:0] act1   = dif_act(bank1_q, pol_q, term_level);
  wire logic       set2_d = dif_hit(bank1_q, act1, `DIF_FN_SET2)
                         || dif_hit(bank1_q, act1, `DIF_FN_SPSET); // [R06]
  wire dif_pkg::dif_bank_t bank = set2_active_q ? bank2_q : bank1_q; // [R06]
  wire logic [5:0] act    = dif_act(bank, pol_q, term_level); // [R09]

  dif_pkg::dif_func_t fn;
  assign fn.forward_run              = dif_hit(bank, act, `DIF_FN_FWD); // [R10]
  assign fn.reverse_run              = dif_hit(bank, act, `DIF_FN_REV); // [R10]
  assign fn.fixed_freq               = {dif_hit(bank, act, `DIF_FN_FF3),
                                        dif_hit(bank, act, `DIF_FN_FF2),
                                        dif_hit(bank, act, `DIF_FN_FF1),
                                        dif_hit(bank, act, `DIF_FN_FF0)}; // [R10]
  assign fn.jog                      = dif_hit(bank, act, `DIF_FN_JOG); // [R11]
  assign fn.dc_brake                 = dif_hit(bank, act, `DIF_FN_DCB); // [R11]
  assign fn.set2_select              = dif_hit(bank, act, `DIF_FN_SET2); // [R11]
  assign fn.alt_ramp_select          = dif_hit(bank, act, `DIF_FN_RAMP2); // [R11]
  assign fn.coast_inhibit            = dif_hit(bank, act, `DIF_FN_COAST); // [R12]
  assign fn.external_fault           = dif_hit(bank, act, `DIF_FN_EXTF); // [R12]
  assign fn.unattended_start_guard   = dif_hit(bank, act, `DIF_FN_USG); // [R12]
  assign fn.param_lock               = dif_hit(bank, act, `DIF_FN_LOCK); // [R12]
  assign fn.analog_source_select     = dif_hit(bank, act, `DIF_FN_ANA); // [R12]
  assign fn.fault_reset              = dif_hit(bank, act, `DIF_FN_FRST); // [R12]
  assign fn.thermistor_input         = dif_hit(bank, act, `DIF_FN_THERM); // [R13]
  assign fn.three_wire_start         = dif_hit(bank, act, `DIF_FN_3START); // [R14]
  assign fn.three_wire_stop          = dif_hit(bank, act, `DIF_FN_3STOP); // [R14]
  assign fn.three_wire_dir           = dif_hit(bank, act, `DIF_FN_3DIR); // [R14]
  assign fn.process_loop_enable      = dif_hit(bank, act, `DIF_FN_PLOOP); // [R15]
  assign fn.integral_clear           = dif_hit(bank, act, `DIF_FN_ICLR); // [R15]
  assign fn.motor_pot_raise          = dif_hit(bank, act, `DIF_FN_POTUP); // [R15]
  assign fn.motor_pot_lower          = dif_hit(bank, act, `DIF_FN_POTDN); // [R15]
  assign fn.motor_pot_clear          = dif_hit(bank, act, `DIF_FN_POTCLR); // [R15]
  assign fn.keypad_priority          = dif_hit(bank, act, `DIF_FN_KEYPAD); // [R16]
  assign fn.freq_offset_add          = dif_hit(bank, act, `DIF_FN_FADD); // [R16]
  assign fn.terminal_source_priority = dif_hit(bank, act, `DIF_FN_TERMPRI); // [R16]
  assign fn.fast_response            = dif_hit(bank, act, `DIF_FN_FAST); // [R16]
  assign fn.special_second_set       = dif_hit(bank, act, `DIF_FN_SPSET); // [R16]

  // Run decode. There is deliberately no start interlock here: a run input
  // already active when reset releases starts the motor on the next edge.
  dif_pkg::dif_drive_t drv;
  assign drv.run_fwd   = fn.forward_run && !fn.reverse_run; // [R01] [R04]
  assign drv.run_rev   = fn.reverse_run && !fn.forward_run; // [R02] [R04]
  assign drv.coast     = fn.forward_run && fn.reverse_run; // [R03]
  assign drv.decel     = !fn.forward_run && !fn.reverse_run; // [R01] [R02]
  assign drv.phase_rev = drv.run_rev; // [R02]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      func_q        <= '0;
      drive_q       <= '0;
      set2_active_q <= 1'b0;
    end else begin
      func_q        <= fn;
      drive_q       <= drv;
      set2_active_q <= set2_d;
    end
  end

  property p_fwd;
    @(posedge clk) disable iff (reset)
      fn.forward_run && !fn.reverse_run |=> drive_q.run_fwd && !drive_q.phase_rev;
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward run not decoded"); // [R01]

  property p_rev;
    @(posedge clk) disable iff (reset)
      fn.reverse_run && !fn.forward_run |=> drive_q.run_rev && drive_q.phase_rev;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse run not decoded"); // [R02]

  property p_coast;
    @(posedge clk) disable iff (reset)
      fn.forward_run && fn.reverse_run
        |=> drive_q.coast && !drive_q.run_fwd && !drive_q.run_rev;
  endproperty
  a_coast: assert property (p_coast) else $error("both run inputs did not coast"); // [R03]

  property p_nodup;
    @(posedge clk) disable iff (reset)
      !dif_any_dup(bank1_q) && !dif_any_dup(bank2_q);
  endproperty
  a_nodup: assert property (p_nodup) else $error("duplicate function code stored"); // [R07]

  property p_therm;
    @(posedge clk) disable iff (reset)
      cfg_wr && !sel_pol && reg_wdata == `DIF_FN_THERM && idx != `DIF_THERM_INPUT
        |=> cfg_reject_q && $stable(bank1_q) && $stable(bank2_q);
  endproperty
  a_therm: assert property (p_therm) else $error("thermistor code taken off input five"); // [R13]

  property p_run_lock;
    @(posedge clk) disable iff (reset)
      cfg_wr && drive_running
        |=> cfg_reject_q && $stable(bank1_q) && $stable(bank2_q) && $stable(pol_q);
  endproperty
  a_run_lock: assert property (p_run_lock) else $error("config written while running"); // [R22]

  // An open reset contact set to the closed type must still read as inactive.
  property p_force_no;
    @(posedge clk) disable iff (reset)
      bank[4] == `DIF_FN_FRST && pol_q[4] && !term_level[4] |=> !func_q.fault_reset;
  endproperty
  a_force_no: assert property (p_force_no) else $error("fault reset not normally open"); // [R18]

  property p_unused;
    @(posedge clk) disable iff (reset)
      bank == {6{`DIF_FN_NONE}} |=> func_q == '0;
  endproperty
  a_unused: assert property (p_unused) else $error("unassigned input drove a function"); // [R21]

  property p_suspect;
    @(posedge clk) disable iff (reset)
      nvm_fault |=> nvm_suspect_q [*2];
  endproperty
  a_suspect: assert property (p_suspect) else $error("storage fault flag lost"); // [R20]

  property p_polarity;
    @(posedge clk) disable iff (reset)
      bank[0] == `DIF_FN_FWD && bank[1] != `DIF_FN_REV && bank[2] != `DIF_FN_REV
        && bank[3] != `DIF_FN_REV && bank[4] != `DIF_FN_REV && bank[5] != `DIF_FN_REV
        && (term_level[0] != pol_q[0]) |=> drive_q.run_fwd;
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied live"); // [R17]

  // The first edge after reset must see the default map and open contacts.
  // A wrong default here would start a motor on a closed-type contact.
  property p_rst_pol;
    @(posedge clk) disable iff (reset)
      $past(reset) |-> pol_q == `DIF_RST_POL;
  endproperty
  a_rst_pol: assert property (p_rst_pol) else $error("reset polarity wrong"); // [R08]

  property p_rst_map;
    @(posedge clk) disable iff (reset)
      $past(reset) |-> bank1_q == `DIF_RST_BANK && bank2_q == `DIF_RST_BANK;
  endproperty
  a_rst_map: assert property (p_rst_map) else $error("reset function map wrong"); // [R05]

  property p_decel;
    @(posedge clk) disable iff (reset)
      !fn.forward_run && !fn.reverse_run
        |=> drive_q.decel && !drive_q.coast && !drive_q.run_fwd && !drive_q.run_rev;
  endproperty
  a_decel: assert property (p_decel) else $error("run release not decelerated"); // [R01]

  property p_one_way;
    @(posedge clk) disable iff (reset)
      !(drive_q.run_fwd && drive_q.run_rev);
  endproperty
  a_one_way: assert property (p_one_way) else $error("both directions driven"); // [R03]

  property p_phase;
    @(posedge clk) disable iff (reset)
      drive_q.phase_rev == drive_q.run_rev;
  endproperty
  a_phase: assert property (p_phase) else $error("phase order wrong"); // [R02]

  property p_rej_set;
    @(posedge clk) disable iff (reset)
      rej_set |=> cfg_reject_q;
  endproperty
  a_rej_set: assert property (p_rej_set) else $error("refused write not flagged"); // [R07]

  property p_run_hold;
    @(posedge clk) disable iff (reset)
      drive_running |=> $stable(bank1_q) && $stable(bank2_q) && $stable(pol_q);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("config changed while running"); // [R22]

  property p_pol_wr;
    @(posedge clk) disable iff (reset)
      cfg_wr && sel_pol && !drive_running && reg_wdata[7:1] == 7'h00
        |=> pol_q[$past(idx)] == $past(reg_wdata[0]);
  endproperty
  a_pol_wr: assert property (p_pol_wr) else $error("polarity write lost"); // [R17]

  c_coast: cover property (@(posedge clk) disable iff (reset) drive_q.coast);
  c_reject: cover property (@(posedge clk) disable iff (reset) rej_set);
  c_set2: cover property (@(posedge clk) disable iff (reset) $rose(set2_active_q));
  c_rev: cover property (@(posedge clk) disable iff (reset) drive_q.run_rev);
  c_fwd: cover property (@(posedge clk) disable iff (reset) drive_q.run_fwd);

endmodule // dif_mapper
`default_nettype wire

// *** logic/dif_defines.svh ***
// Offsets, reset values and function codes of the drive input function mapper.
`ifndef DIF_DEFINES_SVH
`define DIF_DEFINES_SVH
`define DIF_OFS_BANK1 2'b00
`define DIF_OFS_BANK2 2'b01
`define DIF_OFS_POL 2'b10
`define DIF_OFS_STATUS 5'h18
`define DIF_ST_REJECT 0
`define DIF_ST_SUSPECT 1
`define DIF_RST_BANK {8'h09, 8'h12, 8'h03, 8'h02, 8'h01, 8'h00}
`define DIF_RST_POL 6'h00
`define DIF_THERM_INPUT 3'h4
`define DIF_FN_FWD 8'h00
`define DIF_FN_REV 8'h01
`define DIF_FN_FF0 8'h02
`define DIF_FN_FF1 8'h03
`define DIF_FN_FF2 8'h04
`define DIF_FN_FF3 8'h05
`define DIF_FN_JOG 8'h06
`define DIF_FN_DCB 8'h07
`define DIF_FN_SET2 8'h08
`define DIF_FN_RAMP2 8'h09
`define DIF_FN_COAST 8'h0B
`define DIF_FN_EXTF 8'h0C
`define DIF_FN_USG 8'h0D
`define DIF_FN_LOCK 8'h0F
`define DIF_FN_ANA 8'h10
`define DIF_FN_FRST 8'h12
`define DIF_FN_THERM 8'h13
`define DIF_FN_3START 8'h14
`define DIF_FN_3STOP 8'h15
`define DIF_FN_3DIR 8'h16
`define DIF_FN_PLOOP 8'h17
`define DIF_FN_ICLR 8'h18
`define DIF_FN_POTUP 8'h1B
`define DIF_FN_POTDN 8'h1C
`define DIF_FN_POTCLR 8'h1D
`define DIF_FN_KEYPAD 8'h1F
`define DIF_FN_FADD 8'h32
`define DIF_FN_TERMPRI 8'h33
`define DIF_FN_FAST 8'h34
`define DIF_FN_SPSET 8'h35
`define DIF_FN_NONE 8'hFF
`endif

// *** logic/dif_pkg.sv ***
// Types shared by the drive input function mapper.
`default_nettype none
package dif_pkg;
  typedef logic [5:0][7:0] dif_bank_t;
  typedef struct packed {
    logic       forward_run;
    logic       reverse_run;
    logic [3:0] fixed_freq;
    logic       jog;
    logic       dc_brake;
    logic       set2_select;
    logic       alt_ramp_select;
    logic       coast_inhibit;
    logic       external_fault;
    logic       unattended_start_guard;
    logic       param_lock;
    logic       analog_source_select;
    logic       fault_reset;
    logic       thermistor_input;
    logic       three_wire_start;
    logic       three_wire_stop;
    logic       three_wire_dir;
    logic       process_loop_enable;
    logic       integral_clear;
    logic       motor_pot_raise;
    logic       motor_pot_lower;
    logic       motor_pot_clear;
    logic       keypad_priority;
    logic       freq_offset_add;
    logic       terminal_source_priority;
    logic       fast_response;
    logic       special_second_set;
  } dif_func_t;
  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic coast;
    logic decel;
    logic phase_rev;
  } dif_drive_t;
endpackage : dif_pkg
`default_nettype wire

// *** tb/dif_switch_model.sv ***
// Behavioural model of the field switches wired to the six input terminals.
`default_nettype none
module dif_switch_model (
  input  wire logic       clk,
  input  wire logic [5:0] contact_closed,
  output var  logic [5:0] term_level
);
  timeunit 1ns;
  timeprecision 1ns;

  // A closed contact puts the 24 V supply on its terminal, an open one removes it.
  // The contact settles one clock after the command, like a real relay would lag.
  initial term_level = 6'h00;
  always @(posedge clk) begin
    term_level <= contact_closed;
  end
endmodule // dif_switch_model
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking testbench of the drive input function mapper.
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                clk;
  logic                reset;
  logic [4:0]          reg_addr;
  logic [7:0]          reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_rdata_q;
  logic [5:0]          sw;
  logic [5:0]          term_level;
  logic                drive_running;
  logic                nvm_fault;
  dif_pkg::dif_func_t  func_q;
  dif_pkg::dif_drive_t drive_q;
  logic                set2_active_q;
  logic                cfg_reject_q;
  logic                nvm_suspect_q;
  int                  errors;
  int                  tests_run;
  logic [7:0]          d;
  logic [4:0]          exp_drv;
  // One row per function bit, bit 0 first; the expected strobe is that bit alone.
  logic [7:0] fn_rows [30] = '{8'h35, 8'h34, 8'h33, 8'h32, 8'h1F, 8'h1D, 8'h1C, 8'h1B,
    8'h18, 8'h17, 8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h10, 8'h0F, 8'h0D, 8'h0C, 8'h0B,
    8'h09, 8'h08, 8'h07, 8'h06, 8'h02, 8'h03, 8'h04, 8'h05, 8'h01, 8'h00};
  logic [7:0] rst_bank [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12, 8'h09};

  dif_switch_model sw_model (.clk(clk), .contact_closed(sw), .term_level(term_level));

  dif_mapper dut (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .term_level(term_level), .drive_running(drive_running), .nvm_fault(nvm_fault),
    .func_q(func_q), .drive_q(drive_q), .set2_active_q(set2_active_q),
    .cfg_reject_q(cfg_reject_q), .nvm_suspect_q(nvm_suspect_q)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #10;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #10;
    v = reg_rdata_q;
  endtask

  // Three clocks through the switch model, the set-two select and the decode, then look once settled.
  task automatic settle();
    repeat (3) @(posedge clk);
    #10;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    reset = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    drive_running = 1'b0;
    nvm_fault = 1'b0;
    // Terminal 1 is already closed at power-up, so the drive must start at once.
    sw = 6'h01;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #10;
    `CHK("drive at start", 5'b10000, drive_q)
    for (int i = 0; i < 6; i++) begin
      rd(5'(i), d);
      `CHK("bank1 reset", rst_bank[i], d)
      rd(5'(8 + i), d);
      `CHK("bank2 reset", rst_bank[i], d)
      rd(5'(16 + i), d);
      `CHK("polarity reset", 8'h00, d)
    end
    rd(5'h07, d);
    `CHK("unmapped read", 8'h00, d)
    @(posedge clk) sw <= 6'h03;
    settle();
    `CHK("both run inputs", 5'b00100, drive_q)
    @(posedge clk) sw <= 6'h02;
    settle();
    `CHK("reverse only", 5'b01001, drive_q)
    @(posedge clk) sw <= 6'h00;
    settle();
    `CHK("released", 5'b00010, drive_q)
    wr(5'h10, 8'h01);
    settle();
    `CHK("open input made closed-type", 5'b10000, drive_q)
    wr(5'h10, 8'h00);
    @(posedge clk) drive_running <= 1'b1;
    wr(5'h00, 8'h05);
    `CHK("reject while running", 1'b1, cfg_reject_q)
    rd(5'h18, d);
    `CHK("status while running", 8'h09, d)
    @(posedge clk) drive_running <= 1'b0;
    rd(5'h00, d);
    `CHK("select kept", 8'h00, d)
    wr(5'h18, 8'h01);
    rd(5'h18, d);
    `CHK("status cleared", 8'h00, d)
    // Each of these must be refused: duplicate, thermistor off terminal 5, gap code, bad polarity.
    foreach (rst_bank[i]) begin
      if (i < 4) begin
        wr(5'h18, 8'h01);
        case (i)
          0: wr(5'h00, 8'h01);
          1: wr(5'h00, 8'h13);
          2: wr(5'h00, 8'h0A);
          default: wr(5'h10, 8'h02);
        endcase
        `CHK("refused write flag", 1'b1, cfg_reject_q)
      end
    end
    rd(5'h00, d);
    `CHK("select after refusals", 8'h00, d)
    wr(5'h14, 8'h01);
    settle();
    `CHK("reset input polarity ignored", 30'h0, func_q)
    wr(5'h14, 8'h00);
    @(posedge clk) nvm_fault <= 1'b1;
    @(posedge clk) nvm_fault <= 1'b0;
    rd(5'h18, d);
    `CHK("storage fault flag", 8'h02, d & 8'h02)
    `CHK("storage suspect", 1'b1, nvm_suspect_q)
    wr(5'h05, 8'h08);
    wr(5'h08, 8'h06);
    @(posedge clk) sw <= 6'h21;
    settle();
    `CHK("second set active", 1'b1, set2_active_q)
    `CHK("second bank map", 30'h0090_0000, func_q)
    @(posedge clk) sw <= 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (i != 4) begin
        wr(5'(i), 8'hFF);
      end
    end
    @(posedge clk) sw <= 6'h3F;
    // All terminals stay closed; only terminal 5 carries a function code.
    for (int i = 0; i < 30; i++) begin
      if (fn_rows[i] != 8'h08 && fn_rows[i] != 8'h35) begin
        wr(5'h04, fn_rows[i]);
        settle();
        `CHK("function strobe", 30'h1 << i, func_q)
        exp_drv = (fn_rows[i] == 8'h00) ? 5'b10000 : (fn_rows[i] == 8'h01) ? 5'b01001 : 5'b00010;
        `CHK("run decode", exp_drv, drive_q)
      end
    end
    // With every terminal closed and unassigned nothing may be driven.
    wr(5'h04, 8'hFF);
    settle();
    `CHK("all unassigned", 30'h0, func_q)
    `CHK("unassigned run decode", 5'b00010, drive_q)
    conclude();
  end
endmodule // tb_top
`default_nettype wire
